// *** common/gpc_regs.vh ***
`ifndef GPC_REGS_VH
`define GPC_REGS_VH

// Register index map, word addressed (byte address is four times the index).
`define GPC_ADDR_W         6
`define GPC_IDX_DIR        6'h00
`define GPC_IDX_DIR_CLR    6'h01
`define GPC_IDX_DIR_SET    6'h02
`define GPC_IDX_DIR_INV    6'h03
`define GPC_IDX_LVL        6'h04
`define GPC_IDX_LVL_CLR    6'h05
`define GPC_IDX_LVL_SET    6'h06
`define GPC_IDX_LVL_INV    6'h07
`define GPC_IDX_LAT        6'h08
`define GPC_IDX_LAT_CLR    6'h09
`define GPC_IDX_LAT_SET    6'h0a
`define GPC_IDX_LAT_INV    6'h0b
`define GPC_IDX_ODC        6'h0c
`define GPC_IDX_ODC_CLR    6'h0d
`define GPC_IDX_ODC_SET    6'h0e
`define GPC_IDX_ODC_INV    6'h0f
`define GPC_IDX_CNC        6'h10
`define GPC_IDX_CNC_CLR    6'h11
`define GPC_IDX_CNC_SET    6'h12
`define GPC_IDX_CNC_INV    6'h13

// Alias operation codes, taken from the two low index bits.
`define GPC_OP_W           2
`define GPC_OP_WRITE       2'h0
`define GPC_OP_CLR         2'h1
`define GPC_OP_SET         2'h2
`define GPC_OP_INV         2'h3

// Change-notice control fields.
`define GPC_CNC_ON_BIT     15
`define GPC_CNC_FRZ_BIT    14
`define GPC_CNC_IDLE_STOP_BIT   13

// Reset values.
`define GPC_DIR_RST        16'hffff
`define GPC_ODC_RST        16'h0000
`define GPC_LAT_RST        16'h0000
`define GPC_CNC_RST        3'h0

// Values answered for reads of aliases or unmapped addresses.
`define GPC_RD_UNDEF       32'h0000_0000
`define GPC_PORT_W         16
`define GPC_DATA_W         32

`endif

// *** rtl/gpc_pin_drive.v ***
`timescale 1ns/1ns
// Output stage for the port pins: registered value and enable per pin.
module gpc_pin_drive #(
    parameter WIDTH = 16
) (
    // Clock and reset
    input  wire             ref_clk,
    input  wire             nrst,
    // Configuration
    input  wire [WIDTH-1:0] dir,
    input  wire [WIDTH-1:0] lat,
    input  wire [WIDTH-1:0] odc,
    input  wire [WIDTH-1:0] impl,
    // Pin side
    output reg  [WIDTH-1:0] pin_out,
    output reg  [WIDTH-1:0] pin_oe
);

    reg [WIDTH-1:0] oe_d;
    reg [WIDTH-1:0] out_d;

    always @* begin
        // Open drain only drives zeros; input pins ignore the open-drain bit.
        oe_d  = ~dir & impl & (~odc | ~lat);
        out_d = lat & ~dir & impl & ~odc;
    end

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pin_out <= {WIDTH{1'b0}};
            pin_oe  <= {WIDTH{1'b0}};
        end else begin
            pin_out <= out_d;
            pin_oe  <= oe_d;
        end
    end

endmodule

// *** rtl/gpc_port.v ***
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ns
`include "gpc_regs.vh"

module gpc_port #(
    parameter WIDTH    = `GPC_PORT_W,
    parameter IMPL     = 16'hffff,
    parameter HAS_PORT = 1
) (
    // Clock and reset
    input  wire                   ref_clk,
    input  wire                   nrst,
    // Register port
    input  wire [`GPC_ADDR_W-1:0] reg_addr,
    input  wire [`GPC_DATA_W-1:0] reg_wdata,
    input  wire                   reg_wr,
    input  wire                   reg_rd,
    output reg  [`GPC_DATA_W-1:0] reg_rdata,
    // Processor state
    input  wire                   cpu_debug,
    input  wire                   cpu_idle,
    // Pins
    input  wire [WIDTH-1:0]       pin_in,
    output wire [WIDTH-1:0]       pin_out,
    output wire [WIDTH-1:0]       pin_oe,
    // Change-notice unit state
    output reg                    change_notice_run_q
);

    // Pins left out of a variant, or the whole port, read and act as absent.
    localparam [WIDTH-1:0] IMPL_MASK = HAS_PORT ? IMPL[WIDTH-1:0] : {WIDTH{1'b0}};

    reg [WIDTH-1:0] pin_direction_q;
    reg [WIDTH-1:0] pin_direction_d;
    reg [WIDTH-1:0] output_latch_q;
    reg [WIDTH-1:0] output_latch_d;
    reg [WIDTH-1:0] open_drain_select_q;
    reg [WIDTH-1:0] open_drain_select_d;
    reg             cn_on_q;
    reg             cn_on_d;
    reg             debug_freeze_q;
    reg             debug_freeze_d;
    reg             idle_stop_q;
    reg             idle_stop_d;
    reg [`GPC_DATA_W-1:0] rdata_d;
    reg             run_d;

    wire [WIDTH-1:0]           wval;
    wire [`GPC_OP_W-1:0]       op;
    wire [`GPC_ADDR_W-1:0]     base;

    // Reserved upper bits of a write are dropped.
    assign wval = reg_wdata[WIDTH-1:0];
    assign op   = reg_addr[`GPC_OP_W-1:0];
    assign base = {reg_addr[`GPC_ADDR_W-1:`GPC_OP_W], {`GPC_OP_W{1'b0}}};

    // Apply a plain write or a clear, set or invert alias to a register value.
    function [WIDTH-1:0] apply_op;
        input [WIDTH-1:0]     cur;
        input [WIDTH-1:0]     val;
        input [`GPC_OP_W-1:0] code;
        begin
            case (code)
                `GPC_OP_WRITE: apply_op = val;
                `GPC_OP_CLR:   apply_op = cur & ~val;
                `GPC_OP_SET:   apply_op = cur | val;
                `GPC_OP_INV:   apply_op = cur ^ val;
                default:       apply_op = cur;
            endcase
        end
    endfunction

    // Widen a port value to the bus with unimplemented bits cleared.
    function [`GPC_DATA_W-1:0] rd_word;
        input [WIDTH-1:0] val;
        begin
            rd_word = {{(`GPC_DATA_W-WIDTH){1'b0}}, val & IMPL_MASK};
        end
    endfunction

    always @* begin
        pin_direction_d     = pin_direction_q;
        output_latch_d      = output_latch_q;
        open_drain_select_d = open_drain_select_q;
        cn_on_d             = cn_on_q;
        debug_freeze_d      = debug_freeze_q;
        idle_stop_d         = idle_stop_q;
        if (reg_wr) begin
            case (base)
                `GPC_IDX_DIR: begin
                    pin_direction_d = apply_op(pin_direction_q, wval, op);
                end
                // Pin-level writes land in the latch; there is no separate copy.
                `GPC_IDX_LVL: begin
                    output_latch_d = apply_op(output_latch_q, wval, op);
                end
                `GPC_IDX_LAT: begin
                    output_latch_d = apply_op(output_latch_q, wval, op);
                end
                `GPC_IDX_ODC: begin
                    open_drain_select_d = apply_op(open_drain_select_q, wval, op);
                end
                `GPC_IDX_CNC: begin
                    // Reserved bits 12 to 0 are not stored.
                    cn_on_d = apply_op({{(WIDTH-1){1'b0}}, cn_on_q},
                                       {{(WIDTH-1){1'b0}}, reg_wdata[`GPC_CNC_ON_BIT]},
                                       op) != {WIDTH{1'b0}};
                    debug_freeze_d = apply_op({{(WIDTH-1){1'b0}}, debug_freeze_q},
                                       {{(WIDTH-1){1'b0}}, reg_wdata[`GPC_CNC_FRZ_BIT]},
                                       op) != {WIDTH{1'b0}};
                    idle_stop_d = apply_op({{(WIDTH-1){1'b0}}, idle_stop_q},
                                       {{(WIDTH-1){1'b0}}, reg_wdata[`GPC_CNC_IDLE_STOP_BIT]},
                                       op) != {WIDTH{1'b0}};
                end
                default: begin
                    pin_direction_d = pin_direction_q;
                end
            endcase
        end
        // Outside debug mode the freeze bit is held at zero.
        if (!cpu_debug) begin
            debug_freeze_d = 1'b0;
        end
        pin_direction_d     = pin_direction_d & IMPL_MASK;
        output_latch_d      = output_latch_d & IMPL_MASK;
        open_drain_select_d = open_drain_select_d & IMPL_MASK;
    end

    always @* begin
        rdata_d = `GPC_RD_UNDEF;
        // Alias reads answer the fixed undefined value.
        if (reg_rd && op == `GPC_OP_WRITE) begin
            case (base)
                `GPC_IDX_DIR: rdata_d = rd_word(pin_direction_q);
                `GPC_IDX_LVL: rdata_d = rd_word(pin_in);
                `GPC_IDX_LAT: rdata_d = rd_word(output_latch_q);
                `GPC_IDX_ODC: rdata_d = rd_word(open_drain_select_q);
                `GPC_IDX_CNC: begin
                    rdata_d = `GPC_RD_UNDEF;
                    rdata_d[`GPC_CNC_ON_BIT]   = cn_on_q;
                    rdata_d[`GPC_CNC_FRZ_BIT]  = debug_freeze_q;
                    rdata_d[`GPC_CNC_IDLE_STOP_BIT] = idle_stop_q;
                end
                default: rdata_d = `GPC_RD_UNDEF;
            endcase
        end
    end

    always @* begin
        // The unit runs only when on and not frozen or idled.
        run_d = cn_on_q & ~(debug_freeze_q & cpu_debug) & ~(idle_stop_q & cpu_idle);
    end

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pin_direction_q     <= `GPC_DIR_RST;
            output_latch_q      <= `GPC_LAT_RST;
            open_drain_select_q <= `GPC_ODC_RST;
            cn_on_q             <= 1'b0;
            debug_freeze_q      <= 1'b0;
            idle_stop_q         <= 1'b0;
            reg_rdata           <= `GPC_RD_UNDEF;
            change_notice_run_q <= 1'b0;
        end else begin
            pin_direction_q     <= pin_direction_d;
            output_latch_q      <= output_latch_d;
            open_drain_select_q <= open_drain_select_d;
            cn_on_q             <= cn_on_d;
            debug_freeze_q      <= debug_freeze_d;
            idle_stop_q         <= idle_stop_d;
            reg_rdata           <= rdata_d;
            change_notice_run_q <= run_d;
        end
    end

    gpc_pin_drive #(
        .WIDTH (WIDTH)
    ) u_drive (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .dir     (pin_direction_q),
        .lat     (output_latch_q),
        .odc     (open_drain_select_q),
        .impl    (IMPL_MASK),
        .pin_out (pin_out),
        .pin_oe  (pin_oe)
    );

endmodule

// *** verification/gpc_pin_board.sv ***
`timescale 1ns/1ns
// Board around the pins: a driven pin shows the port's value, a released pin
// shows what the board circuit puts on it, so open-drain highs read the board.
module gpc_pin_board (
    // Port side
    input  wire [15:0] pin_out,
    input  wire [15:0] pin_oe,
    // Board side
    input  wire [15:0] board_lvl,
    output wire [15:0] pin_in
);
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & board_lvl);
endmodule

// *** verification/gpc_port_asserts.sv ***
`timescale 1ns/1ns
`include "gpc_regs.vh"
module gpc_port_asserts #(
    parameter WIDTH = 16,
    parameter IMPL  = 16'hffff
) (
    // Clock and reset
    input wire                   ref_clk,
    input wire                   nrst,
    // Register port
    input wire [`GPC_ADDR_W-1:0] reg_addr,
    input wire [`GPC_DATA_W-1:0] reg_wdata,
    input wire                   reg_wr,
    input wire                   reg_rd,
    input wire [`GPC_DATA_W-1:0] reg_rdata,
    // Processor state
    input wire                   cpu_debug,
    input wire                   cpu_idle,
    // Pins
    input wire [WIDTH-1:0]       pin_in,
    input wire [WIDTH-1:0]       pin_out,
    input wire [WIDTH-1:0]       pin_oe,
    input wire                   change_notice_run_q
);
    localparam [WIDTH-1:0] MASK = IMPL;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    reset_input_a: assert property ($rose(nrst) |-> pin_oe == 0)
        else $error("pins driven after reset");
    alias_read_a: assert property (reg_rd && reg_addr[1:0] != 0 |=> reg_rdata == 0)
        else $error("alias read not zero");
    upper_resv_a: assert property (reg_rd |=> reg_rdata[31:16] == 0)
        else $error("upper read bits set");
    level_read_a: assert property (reg_rd && reg_addr == `GPC_IDX_LVL
        |=> reg_rdata[15:0] == ($past(pin_in) & MASK)) else $error("level read wrong");
    dir_input_a: assert property (reg_wr && reg_addr == `GPC_IDX_DIR ##1 !reg_wr
        |=> (pin_oe & $past(reg_wdata[15:0], 2)) == 0) else $error("input pin driven");
    lat_bound_a: assert property (reg_wr && reg_addr[5:2] inside {4'h1, 4'h2}
        && reg_addr[1:0] == 0 ##1 !reg_wr |=> (pin_out & ~$past(reg_wdata[15:0], 2)) == 0)
        else $error("pin high beyond latch");
    od_low_a: assert property (reg_wr && reg_addr == `GPC_IDX_ODC ##1 !reg_wr
        |=> (pin_out & $past(reg_wdata[15:0], 2)) == 0) else $error("open-drain pin high");
    impl_pins_a: assert property ((pin_oe & ~MASK) == 0)
        else $error("missing pin driven");
    ctrl_resv_a: assert property (reg_rd && reg_addr == `GPC_IDX_CNC
        |=> reg_rdata[12:0] == 0) else $error("control low bits set");
    unit_off_a: assert property (reg_wr && reg_addr == `GPC_IDX_CNC && !reg_wdata[15]
        ##1 !reg_wr |=> !change_notice_run_q) else $error("unit runs while off");
    cover property (change_notice_run_q);
    cover property (reg_rd && reg_addr == `GPC_IDX_LVL);
    cover property (pin_oe != 0 && pin_out != pin_oe);
endmodule
bind gpc_port gpc_port_asserts #(.WIDTH(WIDTH), .IMPL(IMPL)) u_gpc_port_asserts (
    .ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_debug,
    .cpu_idle, .pin_in, .pin_out, .pin_oe, .change_notice_run_q);

// *** verification/tb_gpc_port.sv ***
`timescale 1ns/1ns
`include "gpc_regs.vh"
module tb_gpc_port;
    // Top pin left out so the missing-pin paths are exercised.
    localparam [15:0] IMPL = 16'h7fff;
    reg         ref_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, cpu_debug = 0, cpu_idle = 0;
    reg         chk_q = 0;
    reg  [5:0]  reg_addr = 0, b;
    reg  [31:0] reg_wdata = 0;
    reg  [15:0] board_lvl = 0, v, m, s, t;
    wire [31:0] reg_rdata;
    wire [15:0] pin_in, pin_out, pin_oe;
    wire        change_notice_run_q;
    integer     n_fail = 0, n_compared = 0, seed = 32'h24ece199, i;
    reg  [31:0] exp_q[$];
    always #50 ref_clk = ~ref_clk;
    gpc_port #(.IMPL(IMPL)) u_gpc_port (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cpu_debug(cpu_debug), .cpu_idle(cpu_idle), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .change_notice_run_q(change_notice_run_q));
    gpc_pin_board u_gpc_pin_board (.pin_out(pin_out), .pin_oe(pin_oe),
        .board_lvl(board_lvl), .pin_in(pin_in));
    task check(input [63:0] name, input [31:0] seen, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("wrong value %0s exp %h seen %h", name, exp, seen);
            end
        end
    endtask
    task summarize;
        begin
            // A read whose answer never came back leaves a note behind.
            if (exp_q.size() != 0)
                n_fail = n_fail + 1;
            $display("compared %0d failed %0d", n_compared, n_fail);
            if (n_fail == 0 && n_compared > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    // The gap cycle after each strobe keeps one assignment per signal per step.
    task wr(input [5:0] a, input [15:0] d);
        begin
            @(posedge ref_clk);
            reg_addr <= a;
            reg_wdata <= {16'h0000, d};
            reg_wr <= 1;
            @(posedge ref_clk);
            reg_wr <= 0;
        end
    endtask
    task rd(input [5:0] a, input [15:0] e);
        begin
            @(posedge ref_clk);
            reg_addr <= a;
            reg_rd <= 1;
            exp_q.push_back({16'h0000, e});
            @(posedge ref_clk);
            reg_rd <= 0;
        end
    endtask
    task run_is(input e);
        begin
            repeat (3) @(posedge ref_clk);
            #1;
            check("run", {31'h0, change_notice_run_q}, {31'h0, e});
            @(posedge ref_clk);
        end
    endtask
    always @(posedge ref_clk) begin
        if (chk_q)
            check("rdata", reg_rdata, exp_q.pop_front());
        chk_q <= reg_rd;
    end
    initial begin
        #1000000;
        n_fail = n_fail + 1;
        summarize;
    end
    initial begin
        repeat (20) @(posedge ref_clk);
        nrst <= 1;
        rd(`GPC_IDX_DIR, IMPL);
        rd(`GPC_IDX_ODC, 16'h0000);
        rd(`GPC_IDX_CNC, 16'h0000);
        rd(6'h15, 16'h0000);
        for (i = 0; i < 4; i = i + 1) begin
            if (i != 1) begin
                b = 6'(i * 4);
                v = $random(seed);
                m = $random(seed);
                s = $random(seed);
                t = $random(seed);
                wr(b, v);
                wr(b + 6'h01, m);
                wr(b + 6'h02, s);
                wr(b + 6'h03, t);
                rd(b + 6'h02, 16'h0000);
                rd(b, (((v & ~m) | s) ^ t) & IMPL);
            end
        end
        wr(`GPC_IDX_ODC, 16'h0000);
        wr(`GPC_IDX_DIR, 16'h0000);
        v = $random(seed);
        board_lvl <= ~v;
        wr(`GPC_IDX_LAT, v);
        rd(`GPC_IDX_LVL, v & IMPL);
        wr(`GPC_IDX_DIR, 16'hffff);
        rd(`GPC_IDX_LVL, ~v & IMPL);
        rd(`GPC_IDX_LAT, v & IMPL);
        m = $random(seed);
        wr(`GPC_IDX_LVL, m);
        rd(`GPC_IDX_LAT, m & IMPL);
        wr(`GPC_IDX_LVL_INV, s);
        rd(`GPC_IDX_LAT, (m ^ s) & IMPL);
        wr(`GPC_IDX_ODC, 16'hffff);
        wr(`GPC_IDX_DIR, 16'h0000);
        board_lvl <= 16'h0000;
        rd(`GPC_IDX_LVL, 16'h0000);
        wr(`GPC_IDX_DIR, 16'hffff);
        board_lvl <= v;
        rd(`GPC_IDX_LVL, v & IMPL);
        wr(`GPC_IDX_CNC, 16'he000);
        rd(`GPC_IDX_CNC, 16'ha000);
        run_is(1'b1);
        cpu_idle <= 1;
        run_is(1'b0);
        cpu_idle <= 0;
        cpu_debug <= 1;
        wr(`GPC_IDX_CNC, 16'he000);
        rd(`GPC_IDX_CNC, 16'he000);
        run_is(1'b0);
        cpu_debug <= 0;
        run_is(1'b1);
        rd(`GPC_IDX_CNC, 16'ha000);
        wr(`GPC_IDX_CNC, 16'h1fff);
        rd(`GPC_IDX_CNC, 16'h0000);
        run_is(1'b0);
        wr(`GPC_IDX_CNC_SET, 16'h8000);
        rd(`GPC_IDX_CNC, 16'h8000);
        run_is(1'b1);
        repeat (3) @(posedge ref_clk);
        summarize;
    end
endmodule
